// ---- bench/css_peer.sv ----
// external serial peer: sends a byte on serial clock falls, captures on rises
// assumes it sees whichever side makes the serial clock; edges are seen on the system clock
`timescale 1ns/1ps
`default_nettype none
module css_peer (
  // system
  input wire logic i_clk_sys,
  // bench control
  input wire logic i_load,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx,
  output logic [3:0] o_cnt,
  // serial link
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sdi
);
  logic sck_q = 1'b1;
  logic [7:0] sh_q = 8'h00;
  logic [2:0] hold_q = 3'h0;
  initial begin
    o_rx = 8'h00;
    o_cnt = 4'h0;
    o_sdi = 1'b0;
  end
  always @(posedge i_clk_sys) begin
    sck_q <= i_sck;
    if (i_load) begin
      sh_q <= i_tx;
      o_cnt <= 4'h0;
      hold_q <= 3'h0;
    end else if (sck_q && !i_sck && o_cnt < 4'h8) begin
      o_sdi <= sh_q[o_cnt[2:0]];
    end else if (!sck_q && i_sck && o_cnt < 4'h8) begin
      o_rx <= {i_sdo, o_rx[7:1]};
      o_cnt <= o_cnt + 4'h1;
    end else if (o_cnt == 4'h8) begin
      // hold time over: toggle so stale data never looks valid
      if (hold_q == 3'h7) o_sdi <= ~o_sdi;
      else hold_q <= hold_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the clocked serial shifter top
// assumes the pin clock input idles high and toggles only in the external clock test
`timescale 1ns/1ps
`default_nettype none
module testbench import css_pkg::*;;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_idle_mode = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [31:0] i_wb_adr = 32'h00000000;
  logic [31:0] i_wb_dat = 32'h00000000;
  logic [3:0] i_wb_sel = 4'h0;
  logic o_wb_ack, o_sck, o_sck_oe, o_sdo, i_sdi, o_irq;
  logic [31:0] o_wb_dat;
  logic p_load = 1'b0;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] p_rx;
  logic [3:0] p_cnt;
  logic x_sck = 1'b1;
  logic p_sck;
  int err_total_dummy_unused;
  int err_total = 0;
  int n_tests = 0;

  always #10 i_clk_sys = ~i_clk_sys;

  css_top dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_idle_mode(i_idle_mode),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .i_sck(x_sck), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_sdo(o_sdo), .i_sdi(i_sdi), .o_irq(o_irq));
  // both clocks idle high, so the peer sees whichever one runs
  assign p_sck = o_sck & x_sck;
  css_peer peer (.i_clk_sys(i_clk_sys), .i_load(p_load), .i_tx(p_tx), .o_rx(p_rx), .o_cnt(p_cnt),
    .i_sck(p_sck), .i_sdo(o_sdo), .o_sdi(i_sdi));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= {24'h000000, a};
    i_wb_dat <= {24'h000000, d};
    i_wb_sel <= 4'hf;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    q = o_wb_dat;
    if (n >= 50) err_total++;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, exp});
  endtask

  task automatic wait_stat(input logic [7:0] exp);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_MODE, 8'h00, q);
      n++;
    end while (q[7:0] !== exp && n < 100);
    chk(q, {24'h000000, exp});
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_irq !== 1'b1 && n < 600);
    chk({31'h0, o_irq}, 32'h1);
  endtask

  task automatic pload(input logic [7:0] d);
    @(posedge i_clk_sys);
    p_tx <= d;
    p_load <= 1'b1;
    @(posedge i_clk_sys);
    p_load <= 1'b0;
  endtask

  // pin clock for one byte: each level lasts six system clocks, then it rests high
  task automatic xbyte();
    repeat (16) begin
      repeat (6) @(posedge i_clk_sys);
      x_sck <= ~x_sck;
    end
    repeat (6) @(posedge i_clk_sys);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADR_POWER, 8'h00);
    rd(ADR_XFER, 8'h08);
    rd(ADR_MODE, 8'hf3);
    rd(ADR_IDLE, 8'hbe);
    rd(8'h20, 8'h00);
    wr(ADR_XFER, 8'h31);
    rd(ADR_XFER, 8'h08);
    wr(ADR_POWER, 8'h80);
    wr(ADR_MODE, 8'h04);
    rd(ADR_POWER, 8'h80);
    rd(ADR_MODE, 8'hf3);
  endtask

  task automatic t_tx();
    pload(8'h00);
    wr(ADR_XFER, 8'h40);
    rd(ADR_XFER, 8'h48);
    wr(ADR_DATA, 8'ha5);
    i_idle_mode <= 1'b1;
    wr(ADR_XFER, 8'h80);
    repeat (20) @(posedge i_clk_sys);
    rd(ADR_MODE, 8'hf3);
    wr(ADR_IDLE, 8'h40);
    wait_irq();
    wait_stat(8'hfb);
    chk({24'h0, p_rx}, 32'ha5);
    chk({31'h0, o_sck}, 32'h1);
    pload(8'h00);
    wr(ADR_DATA, 8'h8f);
    wr(ADR_XFER, 8'h00);
    wait_stat(8'hf3);
    chk({24'h0, p_rx}, 32'h8f);
    chk({28'h0, p_cnt}, 32'h8);
    chk({31'h0, o_sck}, 32'h1);
    chk({31'h0, o_sck_oe}, 32'h1);
    i_idle_mode <= 1'b0;
  endtask

  task automatic t_rx();
    int n;
    wr(ADR_XFER, 8'h71);
    pload(8'h3c);
    wr(ADR_XFER, 8'hb1);
    // code 001 gives a low phase of eight system clocks
    n = 0;
    while (o_sck !== 1'b0 && n < 100) begin
      @(negedge i_clk_sys);
      n++;
    end
    n = 0;
    while (o_sck === 1'b0 && n < 50) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(n, 32'h8);
    wait_irq();
    repeat (20) @(posedge i_clk_sys);
    rd(ADR_MODE, 8'hfb);
    wr(ADR_DATA, 8'h55);
    pload(8'hc3);
    rd(ADR_DATA, 8'h3c);
    wr(ADR_XFER, 8'h31);
    rd(ADR_MODE, 8'hff);
    wait_stat(8'hf3);
    rd(ADR_DATA, 8'hc3);
  endtask

  task automatic t_abort();
    wr(ADR_XFER, 8'h60);
    rd(ADR_DATA, 8'h00);
    wr(ADR_DATA, 8'h98);
    pload(8'h11);
    wr(ADR_XFER, 8'ha0);
    @(negedge i_clk_sys);
    chk({31'h0, o_sdo}, 32'h1);
    repeat (20) @(posedge i_clk_sys);
    rd(ADR_MODE, 8'hff);
    wr(ADR_XFER, 8'h60);
    rd(ADR_MODE, 8'hf3);
    chk({31'h0, o_sck}, 32'h1);
    wr(ADR_XFER, 8'h50);
    wr(ADR_DATA, 8'h12);
    wr(ADR_XFER, 8'h90);
    repeat (20) @(posedge i_clk_sys);
    rd(ADR_MODE, 8'hf3);
  endtask

  task automatic t_ext();
    wr(ADR_XFER, 8'h47);
    wr(ADR_DATA, 8'h5a);
    pload(8'h00);
    wr(ADR_XFER, 8'h87);
    wait_irq();
    // next byte goes in before the next shift
    wr(ADR_DATA, 8'h3c);
    xbyte();
    chk({24'h0, p_rx}, 32'h5a);
    chk({31'h0, o_sck_oe}, 32'h0);
    pload(8'h00);
    // run cleared before the next shift
    wr(ADR_XFER, 8'h07);
    xbyte();
    chk({24'h0, p_rx}, 32'h3c);
    wait_stat(8'hf3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_abort();
    t_ext();
    wrap_up();
  end

  // whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- logic/css_clk_if.sv ----
// request and edge events between the shift engine and the clock divider
// assumes one system clock for both ends
`timescale 1ns/1ps
`default_nettype none
interface css_clk_if;
  logic run;
  logic [2:0] sel;
  logic fall;
  logic rise;
  modport gen (input run, input sel, output fall, output rise);
  modport eng (output run, output sel, input fall, input rise);
endinterface
`default_nettype wire

// ---- logic/css_clkgen.sv ----
// internal serial clock divider: alternate fall and rise pulses
// assumes run drops between bytes so each byte starts with a fall
`timescale 1ns/1ps
`default_nettype none
module css_clkgen import css_pkg::*; #(
  parameter int CW = 9
) (
  // system
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // engine side
  css_clk_if.gen clk_if
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] half_m1;
  logic [3:0] shamt;
  logic ph_q;
  logic fall_q;
  logic rise_q;

  if (CW < 9) begin : g_chk
    $error("css_clkgen counter too narrow for slowest rate");
  end

  // half period is 2**(code+base-1) system clocks
  assign shamt = {1'b0, clk_if.sel} + 4'(SCK_EXP_BASE - 1);
  assign half_m1 = (CW'(1) << shamt) - CW'(1);
  assign clk_if.fall = fall_q;
  assign clk_if.rise = rise_q;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      ph_q <= 1'b0;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (!clk_if.run) begin
      cnt_q <= '0;
      ph_q <= 1'b0;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (cnt_q == half_m1) begin
      cnt_q <= '0;
      ph_q <= ~ph_q;
      fall_q <= ~ph_q;
      rise_q <= ph_q;
    end else begin
      cnt_q <= cnt_q + CW'(1);
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- logic/css_pkg.sv ----
// shared constants of the clocked serial 8-bit shifter
// assumes a 32-bit wishbone slave with byte offsets in the low address byte
package css_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_POWER = 8'h00;
  localparam logic [7:0] ADR_XFER = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic [7:0] ADR_MODE = 8'h0c;
  localparam logic [7:0] ADR_IDLE = 8'h10;

  // field positions
  localparam int BIT_EN = 7;
  localparam int BIT_RUN = 7;
  localparam int BIT_ABORT = 6;
  localparam int FLD_MODE_LSB = 4;
  localparam int FLD_SCK_LSB = 0;
  localparam int FLD_IFM_LSB = 2;
  localparam int BIT_IDLE_RUN = 6;

  // transfer modes
  localparam logic [1:0] TM_TX = 2'h0;
  localparam logic [1:0] TM_RSVD = 2'h1;
  localparam logic [1:0] TM_TXRX = 2'h2;
  localparam logic [1:0] TM_RX = 2'h3;

  // interface operating modes
  localparam logic [1:0] IFM_PORT = 2'h0;
  localparam logic [1:0] IFM_SIO = 2'h1;
  localparam logic [1:0] IFM_TWO = 2'h2;

  // serial clock: code 111 is the pin, others give period 2**(code+base)
  localparam logic [2:0] SCK_EXT = 3'h7;
  localparam int SCK_EXP_BASE = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // reset values
  localparam logic [2:0] RST_SCK = 3'h0;
  localparam logic [1:0] RST_MODE = TM_TX;
  localparam logic [1:0] RST_IFM = IFM_PORT;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOAD = 4'h2,
    ST_SHIFT = 4'h4,
    ST_WAIT = 4'h8
  } css_state_e;

endpackage

// ---- logic/css_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
// assumes inputs are levels, not pulses shorter than two clocks
`timescale 1ns/1ps
`default_nettype none
module css_sync #(
  parameter int W = 1
) (
  // system
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("css_sync width below one");
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- logic/css_top.sv ----
// clocked serial 8-bit shifter with wishbone register slave
// assumes classic wishbone, 32-bit data, and an asynchronous serial peer
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - mode field: 00 transmit, 10 transmit and receive, 11 receive, 01 reserved.
// - clock field picks a divided internal rate, or the pin clock for 111.
// - abort stops any transfer at once and clears the active flag.
// - run cleared while sending: finish the byte, then clear the active flag.
// - transmit loads the buffer into the shifter, sends 8 bits lsb first.
// - after loading, the buffer is empty; in mode 00 the interrupt asks for more.
// - internal clock, no new byte: stop the clock and wait for a write.
// - at start the output holds the previous last bit until the first fall.
// - receive shifts lsb first, stores eight bits in the buffer, interrupts.
// - internal clock receive waits until software reads the received byte.
// - run cleared while receiving: store the current byte, then go inactive.
// - a transfer mode change discards buffer contents.
// - buffer has separate read and write storage; reads give received data.
// - transmit data shifts on falling clock, receive samples on rising.
// - internal clock drives the pin, which is high when a transfer starts.
// - write-only operating mode: 00 port, 01 serial, 10 two-wire, 11 reserved.
// - status shows transfer-active and shift-active flags, 1 while busy.
// - writes to the mode address set control; reads return the status.
// - idle-run bit: stop (0) or keep working (1) in the idle mode.
// - enable bit gates operation; other settings are kept while disabled.
module css_top import css_pkg::*; (
  // system
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_idle_mode,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // serial link
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_sdo,
  input wire logic i_sdi,
  // event
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  css_state_e st_q;
  logic en_q, run_q, abort_q;
  logic [1:0] mode_q;
  logic [2:0] sck_q;
  logic [1:0] ifm_q;
  logic idle_run_q;
  logic [7:0] txb_q;
  logic [7:0] rxb_q;
  logic tx_full_q, rx_full_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic sck_prev_q;
  logic [1:0] pin_s;
  logic go, ext_sel, tx_mode, rx_mode, ready, start_ok, shifting, fall;
  logic rise, ext_fall, ext_rise, byte_end, req, wr, rd;
  logic [7:0] adr, wd;
  logic [31:0] rdata;

  css_clk_if clk_if ();

  ////////////////////////////////////////////////////////////////////////////
  // pins and clocks

  css_sync #(.W(2)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_d({i_sck, i_sdi}),
    .o_q(pin_s)
  );

  css_clkgen #(.CW(9)) u_clkgen (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .clk_if(clk_if)
  );

  // edge detect looks only at the second synchroniser flop
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= pin_s[1];
    end
  end

  assign ext_fall = sck_prev_q & ~pin_s[1];
  assign ext_rise = ~sck_prev_q & pin_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // decode of modes

  assign go = en_q && (ifm_q == IFM_SIO) && (!i_idle_mode || idle_run_q);
  assign ext_sel = (sck_q == SCK_EXT);
  assign tx_mode = (mode_q == TM_TX) || (mode_q == TM_TXRX);
  assign rx_mode = (mode_q == TM_TXRX) || (mode_q == TM_RX);
  assign ready = (!tx_mode || tx_full_q) && (!rx_mode || !rx_full_q);
  assign start_ok = run_q && (mode_q != TM_RSVD) && ready;
  assign shifting = (st_q == ST_SHIFT) && go && !abort_q;
  assign fall = ext_sel ? ext_fall : clk_if.fall;
  assign rise = ext_sel ? ext_rise : clk_if.rise;
  assign byte_end = shifting && rise && (cnt_q == BYTE_BITS - 4'h1);
  assign clk_if.run = shifting && !ext_sel;
  assign clk_if.sel = sck_q;

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_IDLE;
    end else if (abort_q) begin
      st_q <= ST_IDLE;
    end else if (go) begin
      unique case (st_q)
        ST_IDLE: begin
          if (start_ok) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          st_q <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (byte_end) begin
            if (!run_q) begin
              st_q <= ST_IDLE;
            end else if (ext_sel) begin
              st_q <= (tx_mode && !tx_full_q) ? ST_IDLE : ST_LOAD;
            end else if (tx_mode && !tx_full_q || rx_mode) begin
              st_q <= ST_WAIT;
            end else begin
              st_q <= ST_LOAD;
            end
          end
        end
        ST_WAIT: begin
          if (!run_q) begin
            st_q <= ST_IDLE;
          end else if (ready) begin
            st_q <= ST_LOAD;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifter, counter and data out
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_q <= RST_BYTE;
      cnt_q <= 4'h0;
      o_sdo <= 1'b0;
    end else if (go && !abort_q) begin
      if (st_q == ST_LOAD) begin
        sh_q <= txb_q;
        cnt_q <= 4'h0;
      end else if (shifting && fall && tx_mode) begin
        o_sdo <= sh_q[0];
      end else if (shifting && rise) begin
        sh_q <= {pin_s[0], sh_q[7:1]};
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sck <= 1'b1;
      o_sck_oe <= 1'b0;
    end else begin
      o_sck_oe <= go && !ext_sel;
      if (!clk_if.run) begin
        o_sck <= 1'b1;
      end else if (clk_if.fall) begin
        o_sck <= 1'b0;
      end else if (clk_if.rise) begin
        o_sck <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr = req && i_wb_we && i_wb_sel[0];
  assign rd = req && !i_wb_we;
  assign adr = i_wb_adr[7:0];
  assign wd = i_wb_dat[7:0];

  always_comb begin
    rdata = 32'h0;
    unique case (adr)
      ADR_POWER: rdata[BIT_EN] = en_q;
      ADR_XFER: rdata[7:0] = {run_q, abort_q, mode_q, 1'b1, sck_q};
      ADR_DATA: rdata[7:0] = rxb_q;
      ADR_MODE: rdata[7:0] = {4'hf, st_q != ST_IDLE, st_q == ST_SHIFT, 2'h3};
      ADR_IDLE: rdata[7:0] = {1'b1, idle_run_q, 5'h1f, 1'b0};
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= rd ? rdata : 32'h0;
    end
  end

  // control registers; only the enable is writable while disabled
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q <= 1'b0;
      run_q <= 1'b0;
      abort_q <= 1'b0;
      mode_q <= RST_MODE;
      sck_q <= RST_SCK;
      ifm_q <= RST_IFM;
      idle_run_q <= 1'b0;
    end else if (wr) begin
      if (adr == ADR_POWER) begin
        en_q <= wd[BIT_EN];
      end
      if (en_q && adr == ADR_XFER) begin
        run_q <= wd[BIT_RUN];
        abort_q <= wd[BIT_ABORT];
        mode_q <= wd[FLD_MODE_LSB +: 2];
        sck_q <= wd[FLD_SCK_LSB +: 3];
      end
      if (en_q && adr == ADR_MODE) begin
        ifm_q <= wd[FLD_IFM_LSB +: 2];
      end
      if (en_q && adr == ADR_IDLE) begin
        idle_run_q <= wd[BIT_IDLE_RUN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data buffer: separate write and read halves
  logic mode_chg;
  assign mode_chg = wr && en_q && (adr == ADR_XFER) && (wd[FLD_MODE_LSB +: 2] != mode_q);

  // load empties buffer; a write in the same cycle wins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      txb_q <= RST_BYTE;
      tx_full_q <= 1'b0;
    end else if (mode_chg) begin
      txb_q <= RST_BYTE;
      tx_full_q <= 1'b0;
    end else if (wr && en_q && adr == ADR_DATA) begin
      txb_q <= wd;
      tx_full_q <= 1'b1;
    end else if (go && !abort_q && st_q == ST_LOAD && tx_mode) begin
      tx_full_q <= 1'b0;
    end
  end

  // store byte; set wins over the read that clears
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rxb_q <= RST_BYTE;
      rx_full_q <= 1'b0;
    end else if (mode_chg) begin
      rxb_q <= RST_BYTE;
      rx_full_q <= 1'b0;
    end else if (byte_end && rx_mode) begin
      rxb_q <= {pin_s[0], sh_q[7:1]};
      rx_full_q <= 1'b1;
    end else if (rd && adr == ADR_DATA) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (byte_end && rx_mode) || (go && !abort_q && st_q == ST_LOAD && mode_q == TM_TX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_byte_end;
    st_q == ST_SHIFT && go && !abort_q && rise && cnt_q == 4'h7;
  endsequence

  sequence s_load_tx;
    st_q == ST_LOAD && go && !abort_q && mode_q == TM_TX;
  endsequence

  AST_ABORT_STOPS: assert property (abort_q |=> st_q == ST_IDLE)
    else $error("abort did not end the transfer");
  AST_LOAD_EMPTIES: assert property (s_load_tx ##0 !(wr && adr == ADR_DATA) |=> !tx_full_q && o_irq)
    else $error("load did not empty buffer and interrupt");
  AST_RX_STORE: assert property (s_byte_end ##0 rx_mode && !mode_chg |=> rx_full_q && o_irq)
    else $error("received byte not stored");
  AST_STOP_END: assert property (s_byte_end ##0 !run_q |=> st_q == ST_IDLE)
    else $error("stopped transfer did not end after byte");
  AST_WAIT_CLK_HIGH: assert property (st_q == ST_WAIT && !ext_sel |=> o_sck)
    else $error("serial clock not halted high in wait");
  AST_START_HIGH: assert property ($rose(st_q == ST_SHIFT) && !ext_sel |-> o_sck [*2])
    else $error("serial clock not high at transfer start");
  AST_SDO_HOLD: assert property (!fall |=> $stable(o_sdo))
    else $error("data out moved without a falling edge");
  AST_CNT_RANGE: assert property (cnt_q <= BYTE_BITS)
    else $error("bit counter beyond eight");
  AST_RD_DATA: assert property (rd && adr == ADR_DATA |=> o_wb_ack && o_wb_dat[7:0] == $past(rxb_q))
    else $error("data read did not return the received byte");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held for more than one cycle");

endmodule
`default_nettype wire
